// *** hdl/timer_two_pkg.sv ***
package timer_two_pkg;

   // register bus
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // register offsets
   localparam logic [7:0] CONTROL_OFS     = 8'hc8;
   localparam logic [7:0] MODE_OFS        = 8'hc9;
   localparam logic [7:0] CAPTURE_LOW_OFS = 8'hca;
   localparam logic [7:0] CAPTURE_HI_OFS  = 8'hcb;
   localparam logic [7:0] COUNT_LOW_OFS   = 8'hcc;
   localparam logic [7:0] COUNT_HI_OFS    = 8'hcd;
   localparam logic [7:0] SPEED_OFS       = 8'hce;

   // control register fields
   localparam int unsigned CTL_OVERFLOW_BIT = 7;
   localparam int unsigned CTL_EXT_FLAG_BIT = 6;
   localparam int unsigned CTL_RX_BAUD_BIT  = 5;
   localparam int unsigned CTL_TX_BAUD_BIT  = 4;
   localparam int unsigned CTL_TRIG_EN_BIT  = 3;
   localparam int unsigned CTL_RUN_BIT      = 2;
   localparam int unsigned CTL_SOURCE_BIT   = 1;
   localparam int unsigned CTL_CAPSEL_BIT   = 0;

   // mode register fields
   localparam int unsigned MOD_AUTO_CLR_HI  = 7;
   localparam int unsigned MOD_AUTO_CLR_LO  = 4;
   localparam int unsigned MOD_CAP_RST_BIT  = 3;
   localparam int unsigned MOD_CLK_OUT_BIT  = 1;
   localparam int unsigned MOD_DOWN_EN_BIT  = 0;
   localparam logic [7:0]  MOD_WRITE_MASK   = 8'hfb;

   // speed register field
   localparam int unsigned SPD_FAST_BIT     = 0;

   // reset values and the count maximum
   localparam logic [7:0]  CONTROL_RST      = 8'h00;
   localparam logic [7:0]  MODE_RST         = 8'h00;
   localparam logic [15:0] COUNT_RST        = 16'h0000;
   localparam logic [15:0] CAPTURE_RST      = 16'h0000;
   localparam logic [15:0] COUNT_MAX        = 16'hffff;

   // timing counts in core clocks per timer tick
   localparam int unsigned SLOW_DIV_CLKS    = 12;
   localparam int unsigned FAST_DIV_CLKS    = 4;
   localparam int unsigned BAUD_DIV_CLKS    = 2;

endpackage

// *** hdl/timer_two.sv ***
`timescale 1ns/1ps

module timer_two
   import timer_two_pkg::*;
#(
   parameter int unsigned SLOW_DIV = SLOW_DIV_CLKS,
   parameter int unsigned FAST_DIV = FAST_DIV_CLKS
) (
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   input  wire logic              external_count_pin_i,
   input  wire logic              trigger_pin_i,
   input  wire logic              timer_one_overflow_i,
   input  wire logic              int_enable_i,
   input  wire logic [3:0]        ext_int_enter_i,
   output logic                   irq_o,
   output logic                   rx_baud_tick_o,
   output logic                   tx_baud_tick_o,
   output logic                   clock_out_o,
   output logic      [3:0]        ext_int_clear_o
);

   // elaboration-time refusal of divider values the four-bit prescaler cannot serve
   if (SLOW_DIV < 2 || SLOW_DIV > 16 || FAST_DIV < 2 || FAST_DIV > 16) begin : gen_bad_div
      $error("timer_two: divider values must lie between 2 and 16");
   end

   localparam logic [3:0] SLOW_LAST = 4'(SLOW_DIV - 1);
   localparam logic [3:0] FAST_LAST = 4'(FAST_DIV - 1);

   function automatic logic fell(input logic prev, input logic cur);
      fell = prev & ~cur;
   endfunction

   // register state
   logic        overflow_flag_q;
   logic        external_event_flag_q;
   logic        rx_baud_select_q;
   logic        tx_baud_select_q;
   logic        trigger_pin_enable_q;
   logic        run_control_q;
   logic        count_source_select_q;
   logic        capture_reload_select_q;
   logic [7:0]  mode_q;
   logic        internal_speed_select_q;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic [15:0] capture_q;
   logic [15:0] capture_d;
   logic [3:0]  presc_q;
   logic        half_q;

   // pin synchronisers, stage 3 only feeds edge detection
   logic cnt_s1_q;
   logic cnt_s2_q;
   logic cnt_s3_q;
   logic trig_s1_q;
   logic trig_s2_q;
   logic trig_s3_q;

   // bus decode
   wire wr_ctrl_w  = wr_i && (addr_i == CONTROL_OFS);
   wire wr_mode_w  = wr_i && (addr_i == MODE_OFS);
   wire wr_capl_w  = wr_i && (addr_i == CAPTURE_LOW_OFS);
   wire wr_caph_w  = wr_i && (addr_i == CAPTURE_HI_OFS);
   wire wr_cntl_w  = wr_i && (addr_i == COUNT_LOW_OFS);
   wire wr_cnth_w  = wr_i && (addr_i == COUNT_HI_OFS);
   wire wr_speed_w = wr_i && (addr_i == SPEED_OFS);

   wire [7:0] control_w = {overflow_flag_q, external_event_flag_q, rx_baud_select_q, tx_baud_select_q,
                           trigger_pin_enable_q, run_control_q, count_source_select_q,
                           capture_reload_select_q};

   wire [7:0] rdata_w = (addr_i == CONTROL_OFS)     ? control_w :
                        (addr_i == MODE_OFS)        ? mode_q :
                        (addr_i == CAPTURE_LOW_OFS) ? capture_q[7:0] :
                        (addr_i == CAPTURE_HI_OFS)  ? capture_q[15:8] :
                        (addr_i == COUNT_LOW_OFS)   ? count_q[7:0] :
                        (addr_i == COUNT_HI_OFS)    ? count_q[15:8] :
                        (addr_i == SPEED_OFS)       ? {7'h00, internal_speed_select_q} :
                                                      8'h00;

   // mode decode
   wire baud_w        = rx_baud_select_q | tx_baud_select_q;
   wire reload_mode_w = baud_w | ~capture_reload_select_q;
   wire down_en_w     = mode_q[MOD_DOWN_EN_BIT] & reload_mode_w & ~baud_w;
   wire down_w        = down_en_w & ~trig_s2_q;

   // tick generation
   wire [3:0] presc_last_w = internal_speed_select_q ? FAST_LAST : SLOW_LAST;
   wire presc_tick_w  = (presc_q == presc_last_w);
   wire cnt_fall_w    = fell(cnt_s3_q, cnt_s2_q);
   wire trig_fall_w   = fell(trig_s3_q, trig_s2_q);
   wire src_tick_w    = count_source_select_q ? cnt_fall_w : presc_tick_w;
   wire tick_w        = run_control_q & (baud_w ? half_q : src_tick_w);

   // events
   wire up_ovf_w   = tick_w & ~down_w & (count_q == COUNT_MAX);
   wire dn_ovf_w   = tick_w & down_w & (count_q == capture_q);
   wire ovf_w      = up_ovf_w | dn_ovf_w;
   wire edge_w     = trigger_pin_enable_q & trig_fall_w;
   wire cap_evt_w  = edge_w & ~baud_w & capture_reload_select_q;
   wire rel_evt_w  = edge_w & ~baud_w & ~capture_reload_select_q & ~down_en_w;
   wire tf_set_w   = ovf_w & ~baud_w;
   wire exf_set_w  = edge_w | (ovf_w & down_en_w);

   always_comb begin
      count_d = count_q;
      if (cap_evt_w && mode_q[MOD_CAP_RST_BIT]) begin
         count_d = COUNT_RST;
      end else if (rel_evt_w) begin
         count_d = capture_q;
      end else if (up_ovf_w) begin
         count_d = reload_mode_w ? capture_q : COUNT_RST;
      end else if (dn_ovf_w) begin
         count_d = COUNT_MAX;
      end else if (tick_w) begin
         count_d = down_w ? count_q - 16'h0001 : count_q + 16'h0001;
      end
      if (wr_cntl_w) begin
         count_d[7:0] = wdata_i;
      end
      if (wr_cnth_w) begin
         count_d[15:8] = wdata_i;
      end
   end

   always_comb begin
      capture_d = capture_q;
      if (cap_evt_w) begin
         capture_d = count_q;
      end
      if (wr_capl_w) begin
         capture_d[7:0] = wdata_i;
      end
      if (wr_caph_w) begin
         capture_d[15:8] = wdata_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cnt_s1_q  <= 1'b1;
         cnt_s2_q  <= 1'b1;
         cnt_s3_q  <= 1'b1;
         trig_s1_q <= 1'b1;
         trig_s2_q <= 1'b1;
         trig_s3_q <= 1'b1;
      end else begin
         cnt_s1_q  <= external_count_pin_i;
         cnt_s2_q  <= cnt_s1_q;
         cnt_s3_q  <= cnt_s2_q;
         trig_s1_q <= trigger_pin_i;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || !run_control_q || presc_tick_w) begin
         presc_q <= 4'h0;
      end else begin
         presc_q <= presc_q + 4'h1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || !run_control_q || !baud_w) begin
         half_q <= 1'b0;
      end else begin
         half_q <= ~half_q;
      end
   end

   // flags: hardware set wins over a software clear in the same cycle
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         overflow_flag_q       <= CONTROL_RST[CTL_OVERFLOW_BIT];
         external_event_flag_q <= CONTROL_RST[CTL_EXT_FLAG_BIT];
      end else begin
         overflow_flag_q       <= (wr_ctrl_w ? wdata_i[CTL_OVERFLOW_BIT] : overflow_flag_q)
                                  | tf_set_w;
         external_event_flag_q <= (wr_ctrl_w ? wdata_i[CTL_EXT_FLAG_BIT] : external_event_flag_q)
                                  | exf_set_w;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rx_baud_select_q        <= CONTROL_RST[CTL_RX_BAUD_BIT];
         tx_baud_select_q        <= CONTROL_RST[CTL_TX_BAUD_BIT];
         trigger_pin_enable_q    <= CONTROL_RST[CTL_TRIG_EN_BIT];
         run_control_q           <= CONTROL_RST[CTL_RUN_BIT];
         count_source_select_q   <= CONTROL_RST[CTL_SOURCE_BIT];
         capture_reload_select_q <= CONTROL_RST[CTL_CAPSEL_BIT];
      end else if (wr_ctrl_w) begin
         rx_baud_select_q        <= wdata_i[CTL_RX_BAUD_BIT];
         tx_baud_select_q        <= wdata_i[CTL_TX_BAUD_BIT];
         trigger_pin_enable_q    <= wdata_i[CTL_TRIG_EN_BIT];
         run_control_q           <= wdata_i[CTL_RUN_BIT];
         count_source_select_q   <= wdata_i[CTL_SOURCE_BIT];
         capture_reload_select_q <= wdata_i[CTL_CAPSEL_BIT];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mode_q                  <= MODE_RST;
         internal_speed_select_q <= 1'b0;
      end else begin
         if (wr_mode_w) begin
            mode_q <= wdata_i & MOD_WRITE_MASK;
         end
         if (wr_speed_w) begin
            internal_speed_select_q <= wdata_i[SPD_FAST_BIT];
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         count_q   <= COUNT_RST;
         capture_q <= CAPTURE_RST;
      end else begin
         count_q   <= count_d;
         capture_q <= capture_d;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_o         <= 8'h00;
         irq_o           <= 1'b0;
         rx_baud_tick_o  <= 1'b0;
         tx_baud_tick_o  <= 1'b0;
         clock_out_o     <= 1'b0;
         ext_int_clear_o <= 4'h0;
      end else begin
         rdata_o         <= rd_i ? rdata_w : 8'h00;
         irq_o           <= int_enable_i & (overflow_flag_q | external_event_flag_q);
         rx_baud_tick_o  <= rx_baud_select_q ? up_ovf_w : timer_one_overflow_i;
         tx_baud_tick_o  <= tx_baud_select_q ? up_ovf_w : timer_one_overflow_i;
         clock_out_o     <= mode_q[MOD_CLK_OUT_BIT] ? (clock_out_o ^ ovf_w) : 1'b0;
         ext_int_clear_o <= mode_q[MOD_AUTO_CLR_HI:MOD_AUTO_CLR_LO] & ext_int_enter_i;
      end
   end

   // checks
   chk_overflow_sets_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (tick_w && !down_w && count_q == COUNT_MAX && !baud_w) |=> overflow_flag_q)
      else $error("overflow did not set the overflow flag");

   chk_down_match_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (tick_w && down_w && count_q == capture_q && !wr_cntl_w && !wr_cnth_w)
      |=> (overflow_flag_q && count_q == COUNT_MAX))
      else $error("down-count match did not set flag and reload maximum");

   chk_baud_no_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (baud_w && !overflow_flag_q && !wr_ctrl_w) |=> !overflow_flag_q)
      else $error("overflow flag set in baud-generator use");

   chk_flag_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (overflow_flag_q && !wr_ctrl_w) |=> overflow_flag_q)
      else $error("hardware cleared the overflow flag");

   chk_edge_sets_ext: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (trigger_pin_enable_q && trig_s3_q && !trig_s2_q) |=> external_event_flag_q)
      else $error("trigger edge did not set the external flag");

   chk_irq_from_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (int_enable_i && (overflow_flag_q || external_event_flag_q)) |=> irq_o)
      else $error("interrupt request missing while a flag is set");

   chk_sw_ext_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_ctrl_w && wdata_i[CTL_EXT_FLAG_BIT]) ##1 int_enable_i |=> irq_o)
      else $error("software external flag did not raise the interrupt");

   chk_trigger_ignored: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!trigger_pin_enable_q && !wr_capl_w && !wr_caph_w) |=> $stable(capture_q))
      else $error("capture pair changed with the trigger pin disabled");

   chk_stop_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!run_control_q && !wr_cntl_w && !wr_cnth_w && !cap_evt_w && !rel_evt_w) |=> $stable(count_q))
      else $error("count moved while the timer was stopped");

   chk_baud_rate: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (tick_w && baud_w && run_control_q && !wr_ctrl_w) ##1 !wr_ctrl_w |-> !tick_w ##1 tick_w)
      else $error("baud-generator rate is not one tick every two clocks");

   chk_capture_copy: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cap_evt_w && !wr_capl_w && !wr_caph_w) |=> capture_q == $past(count_q))
      else $error("capture pair did not take the count");

   chk_capture_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cap_evt_w && mode_q[MOD_CAP_RST_BIT] && !wr_cntl_w && !wr_cnth_w) |=> count_q == COUNT_RST)
      else $error("capture reset did not clear the count");

   chk_clock_out_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !mode_q[MOD_CLK_OUT_BIT] |=> !clock_out_o)
      else $error("clock-out active while disabled");

   chk_auto_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (mode_q[MOD_AUTO_CLR_HI] && ext_int_enter_i[3]) |=> ext_int_clear_o[3])
      else $error("external interrupt 5 flag not cleared on entry");

   // reload, direction, flag and output-source checks
   chk_up_reload: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (up_ovf_w && reload_mode_w && !wr_cntl_w && !wr_cnth_w)
      |=> count_q == $past(capture_q))
      else $error("overflow did not reload the count from the capture pair");

   chk_edge_reload: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (rel_evt_w && !wr_cntl_w && !wr_cnth_w) |=> count_q == $past(capture_q))
      else $error("trigger edge did not reload the count");

   chk_count_down_dir: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (tick_w && down_w && count_q != capture_q && !wr_cntl_w && !wr_cnth_w)
      |=> count_q == $past(count_q) - 16'h0001)
      else $error("down counting did not step the count down");

   chk_trigger_no_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!trigger_pin_enable_q && !external_event_flag_q && !(ovf_w && down_en_w) && !wr_ctrl_w)
      |=> !external_event_flag_q)
      else $error("external flag set with the trigger pin disabled");

   chk_rx_source: assert property (@(posedge core_clk_i) disable iff (rst_i)
      rx_baud_select_q |=> rx_baud_tick_o == $past(up_ovf_w))
      else $error("receive time-base does not follow this timer overflow");

   chk_tx_source: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !tx_baud_select_q |=> tx_baud_tick_o == $past(timer_one_overflow_i))
      else $error("transmit time-base does not follow timer 1 overflow");

   chk_clock_out_toggle: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (mode_q[MOD_CLK_OUT_BIT] && ovf_w) |=> clock_out_o != $past(clock_out_o))
      else $error("clock-out did not toggle on overflow");

   chk_ext_on_down: assert property (@(posedge core_clk_i) disable iff (rst_i)
      dn_ovf_w |=> external_event_flag_q)
      else $error("down-count match did not set the external flag");

   chk_irq_flags_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !(overflow_flag_q || external_event_flag_q) |=> !irq_o)
      else $error("interrupt request raised with both flags clear");

endmodule

// *** tb/pin_partner.sv ***
`timescale 1ns/1ps
module pin_partner (
   input  wire logic clk_i,
   input  wire logic cnt_fall_i,
   input  wire logic trig_fall_i,
   input  wire logic trig_hold_low_i,
   output logic      count_pin_o,
   output logic      trig_pin_o
);
   logic [2:0] cnt_low_q  = 3'h0;
   logic [2:0] trig_low_q = 3'h0;
   // a requested falling edge is a low pulse long enough to pass the pin synchronisers
   always @(posedge clk_i) begin
      cnt_low_q  <= cnt_fall_i ? 3'h5 : ((cnt_low_q != 3'h0) ? cnt_low_q - 3'h1 : 3'h0);
      trig_low_q <= trig_fall_i ? 3'h5 : ((trig_low_q != 3'h0) ? trig_low_q - 3'h1 : 3'h0);
   end
   // both pins idle at their pull-up level
   assign count_pin_o = (cnt_low_q == 3'h0);
   assign trig_pin_o  = (trig_low_q == 3'h0) && !trig_hold_low_i;
endmodule

// *** tb/timer_two_capture_reload_tb.sv ***
`timescale 1ns/1ps
module timer_two_capture_reload_tb;
   import timer_two_pkg::*;
   logic        core_clk_i, rst_i, wr_i, rd_i, t1_ovf, int_en, cnt_fall, trig_fall, hold_low;
   logic        cnt_pin, trig_pin, irq_o, rx_tick, tx_tick, clk_out, last;
   logic [7:0]  addr_i, wdata_i, rdata_o, d, d2;
   logic [3:0]  enter, clr_o;
   logic [31:0] r;
   int          err_count, n_compared, cycles, nrx, ntog;

   timer_two #(.SLOW_DIV(12), .FAST_DIV(4)) DUT (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .external_count_pin_i(cnt_pin), .trigger_pin_i(trig_pin),
      .timer_one_overflow_i(t1_ovf), .int_enable_i(int_en), .ext_int_enter_i(enter), .irq_o(irq_o),
      .rx_baud_tick_o(rx_tick), .tx_baud_tick_o(tx_tick), .clock_out_o(clk_out), .ext_int_clear_o(clr_o));

   pin_partner u_pins (.clk_i(core_clk_i), .cnt_fall_i(cnt_fall), .trig_fall_i(trig_fall),
      .trig_hold_low_i(hold_low), .count_pin_o(cnt_pin), .trig_pin_o(trig_pin));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [3:0] exp_clear(input logic [7:0] m, input logic [3:0] e);
      return m[7:4] & e;
   endfunction

   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi, input string msg);
      n_compared++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         $display("mismatch at %0t: %s got %h", $time, msg, got);
         err_count++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   task automatic pulse_trig();
      @(posedge core_clk_i);
      trig_fall <= 1'b1;
      @(posedge core_clk_i);
      trig_fall <= 1'b0;
      repeat (10) @(posedge core_clk_i);
   endtask

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // hang guard
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         report_and_stop();
      end
   end

   initial begin
      rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00; t1_ovf = 1'b0;
      int_en = 1'b1; enter = 4'h0; cnt_fall = 1'b0; trig_fall = 1'b0; hold_low = 1'b0;
      r = 32'h31ceb858; err_count = 0; n_compared = 0; cycles = 0;
      repeat (5) @(posedge core_clk_i);
      rst_i <= 1'b0;
      for (int a = 8'hc8; a <= 8'hcf; a++) begin
         rd(a[7:0], d);
         check(d, 8'h00, 8'h00, "reset value");
      end
      wr(8'h10, 8'ha5);
      rd(8'h10, d);
      check(d, 8'h00, 8'h00, "unmapped read");
      // auto-clear pulses and mode readback, random
      for (int i = 0; i < 6; i++) begin
         r = lfsr_next(r);
         wr(MODE_OFS, r[7:0]);
         rd(MODE_OFS, d);
         check(d, r[7:0] & MOD_WRITE_MASK, r[7:0] & MOD_WRITE_MASK, "mode readback");
         @(posedge core_clk_i);
         enter <= r[11:8];
         @(posedge core_clk_i);
         enter <= 4'h0;
         #1 check(clr_o, exp_clear(r[7:0], r[11:8]), exp_clear(r[7:0], r[11:8]), "auto clear");
      end
      wr(MODE_OFS, 8'h00);
      // up count with reload from the capture pair
      wr(CAPTURE_LOW_OFS, 8'h34);
      wr(CAPTURE_HI_OFS, 8'h12);
      wr(COUNT_LOW_OFS, 8'hfe);
      wr(COUNT_HI_OFS, 8'hff);
      wr(SPEED_OFS, 8'h01);
      wr(CONTROL_OFS, 8'h04);
      repeat (20) @(posedge core_clk_i);
      rd(CONTROL_OFS, d2);
      check(d2, 8'h84, 8'h84, "overflow flag");
      wr(CONTROL_OFS, 8'h80);
      rd(COUNT_HI_OFS, d);
      check(d, 8'h12, 8'h12, "reload high");
      rd(COUNT_LOW_OFS, d);
      check(d, 8'h35, 8'h3a, "reload low");
      rd(CONTROL_OFS, d2);
      check(d2, 8'h80, 8'h80, "software flag set");
      check(irq_o, 1'b1, 1'b1, "irq level");
      repeat (10) @(posedge core_clk_i);
      rd(COUNT_LOW_OFS, d2);
      check(d2, d, d, "stopped count held");
      wr(CONTROL_OFS, 8'h00);
      repeat (3) @(posedge core_clk_i);
      #1 check(irq_o, 1'b0, 1'b0, "irq after clear");
      wr(CONTROL_OFS, 8'h40);
      repeat (2) @(posedge core_clk_i);
      #1 check(irq_o, 1'b1, 1'b1, "software external flag irq");
      wr(CONTROL_OFS, 8'h00);
      // capture, then capture with count reset; second pass with interrupt disabled
      for (int i = 0; i < 2; i++) begin
         r = lfsr_next(r);
         int_en <= (i == 0);
         wr(MODE_OFS, (i == 0) ? 8'h00 : 8'h08);
         wr(CONTROL_OFS, 8'h09);
         wr(COUNT_LOW_OFS, r[7:0]);
         wr(COUNT_HI_OFS, r[15:8]);
         pulse_trig();
         rd(CAPTURE_LOW_OFS, d);
         rd(CAPTURE_HI_OFS, d2);
         check({d2, d}, r[15:0], r[15:0], "capture pair");
         rd(CONTROL_OFS, d);
         check(d, 8'h49, 8'h49, "external flag");
         check(irq_o, (i == 0), (i == 0), "trigger irq");
         rd(COUNT_LOW_OFS, d);
         check(d, (i == 0) ? r[7:0] : 8'h00, (i == 0) ? r[7:0] : 8'h00, "capture reset");
         wr(CONTROL_OFS, 8'h00);
      end
      int_en <= 1'b1;
      // trigger disabled: no capture, no flag
      wr(MODE_OFS, 8'h00);
      wr(CONTROL_OFS, 8'h01);
      wr(COUNT_LOW_OFS, ~r[7:0]);
      pulse_trig();
      rd(CONTROL_OFS, d);
      check(d, 8'h01, 8'h01, "trigger ignored");
      rd(CAPTURE_LOW_OFS, d);
      check(d, r[7:0], r[7:0], "capture unchanged");
      // reload mode with the trigger enabled: an edge reloads the count
      wr(CONTROL_OFS, 8'h08);
      pulse_trig();
      rd(COUNT_LOW_OFS, d);
      check(d, r[7:0], r[7:0], "trigger reload");
      rd(CONTROL_OFS, d);
      check(d, 8'h48, 8'h48, "reload edge flag");
      // external pin counting
      wr(COUNT_LOW_OFS, 8'h00);
      wr(COUNT_HI_OFS, 8'h00);
      wr(CONTROL_OFS, 8'h06);
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk_i);
         cnt_fall <= 1'b1;
         @(posedge core_clk_i);
         cnt_fall <= 1'b0;
         repeat (10) @(posedge core_clk_i);
      end
      rd(COUNT_LOW_OFS, d);
      check(d, 8'h03, 8'h03, "pin edge count");
      // down count with trigger held low
      wr(CONTROL_OFS, 8'h00);
      wr(MODE_OFS, 8'h01);
      wr(CAPTURE_LOW_OFS, 8'h05);
      wr(CAPTURE_HI_OFS, 8'h00);
      wr(COUNT_LOW_OFS, 8'h07);
      hold_low <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      wr(CONTROL_OFS, 8'h04);
      repeat (20) @(posedge core_clk_i);
      rd(CONTROL_OFS, d);
      check(d, 8'hc4, 8'hc4, "down match flags");
      rd(COUNT_HI_OFS, d);
      check(d, 8'hff, 8'hff, "down reload max");
      wr(CONTROL_OFS, 8'h00);
      hold_low <= 1'b0;
      // receive baud use with clock-out, timer 1 ticks on the transmit side
      wr(MODE_OFS, 8'h02);
      wr(CAPTURE_LOW_OFS, 8'hfe);
      wr(CAPTURE_HI_OFS, 8'hff);
      wr(COUNT_LOW_OFS, 8'hfe);
      wr(COUNT_HI_OFS, 8'hff);
      wr(CONTROL_OFS, 8'h24);
      nrx = 0;
      ntog = 0;
      last = 1'b0;
      d = 8'h00;
      for (int i = 0; i < 40; i++) begin
         r = lfsr_next(r);
         @(posedge core_clk_i);
         t1_ovf <= r[0];
         #1 check(tx_tick, last, last, "timer one time-base");
         last = r[0];
         nrx += rx_tick;
         ntog += (clk_out != d[0]);
         d[0] = clk_out;
      end
      check(nrx, 9, 11, "baud tick rate");
      check(ntog, 9, 11, "clock-out toggles");
      rd(CONTROL_OFS, d);
      check(d, 8'h24, 8'h24, "no flag in baud use");
      wr(CONTROL_OFS, 8'h00);
      wr(MODE_OFS, 8'h00);
      repeat (3) @(posedge core_clk_i);
      #1 check(clk_out, 1'b0, 1'b0, "clock-out off");
      // slow internal rate: ticks at 12, 24, 36 and 48 clocks after run
      wr(SPEED_OFS, 8'h00);
      wr(COUNT_LOW_OFS, 8'h00);
      wr(COUNT_HI_OFS, 8'h00);
      wr(CONTROL_OFS, 8'h04);
      repeat (46) @(posedge core_clk_i);
      wr(CONTROL_OFS, 8'h00);
      rd(COUNT_LOW_OFS, d);
      check(d, 8'h04, 8'h04, "slow internal rate");
      report_and_stop();
   end
endmodule
